// >>> hw/epw_frame_rx.sv
`timescale 1ns/1ps
module epw_frame_rx (
  input wire logic link_sclk,
  input wire logic frame_clr,
  input wire epw_pkg::epw_mode_t mode,
  input wire logic serial_in,
  input wire logic dc_select,
  output logic last_bit,
  output logic [7:0] byte_next,
  output logic dc_next
);

  epw_pkg::epw_frame_t st_reg;
  epw_pkg::epw_frame_t st_next;

  // input only: nothing here can drive back toward the host
  always_comb
  begin
    st_next = st_reg;
    last_bit = 1'b0;
    byte_next = {st_reg.shift[6:0], serial_in};
    // 3-wire frames carry their own flag; the pin is not looked at
    dc_next = (mode == epw_pkg::EPW_MODE_4W) ? dc_select : st_reg.flag;
    unique case (mode)
      epw_pkg::EPW_MODE_4W:
      begin
        st_next.shift = byte_next;
        if (st_reg.cnt == epw_pkg::LAST_4W)
        begin
          last_bit = !frame_clr;
          st_next.cnt = '0;
        end
        else
          st_next.cnt = st_reg.cnt + 4'h1;
      end
      epw_pkg::EPW_MODE_3W:
      begin
        if (st_reg.cnt == epw_pkg::FLAG_IDX)
        begin
          st_next.flag = serial_in;
          st_next.cnt = st_reg.cnt + 4'h1;
        end
        else
        begin
          st_next.shift = byte_next;
          if (st_reg.cnt == epw_pkg::LAST_3W)
          begin
            last_bit = !frame_clr;
            st_next.cnt = '0;
          end
          else
            st_next.cnt = st_reg.cnt + 4'h1;
        end
      end
    endcase
  end

  // chip select high wipes any partial frame; the link clock may be still
  always_ff @(posedge link_sclk or posedge frame_clr)
  begin
    if (frame_clr)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  a_cnt_range_4w: assert property (@(posedge link_sclk) disable iff (frame_clr)
    mode == epw_pkg::EPW_MODE_4W |-> st_reg.cnt <= epw_pkg::LAST_4W)
    else $error("4-wire bit counter past the eighth bit");

  a_msb_first: assert property (@(posedge link_sclk) disable iff (frame_clr)
    (mode == epw_pkg::EPW_MODE_4W && last_bit) |-> byte_next[7] == $past(serial_in, 7))
    else $error("4-wire byte not assembled msb first");

  a_flag_first: assert property (@(posedge link_sclk) disable iff (frame_clr)
    (mode == epw_pkg::EPW_MODE_3W && st_reg.cnt == epw_pkg::FLAG_IDX) |=> st_reg.flag == $past(serial_in))
    else $error("3-wire flag not taken from the first bit");

  a_last_3w: assert property (@(posedge link_sclk) disable iff (frame_clr)
    (mode == epw_pkg::EPW_MODE_3W && last_bit) |-> (st_reg.cnt == epw_pkg::LAST_3W && dc_next == st_reg.flag))
    else $error("3-wire byte committed at wrong bit or with wrong flag");

endmodule : epw_frame_rx

// >>> hw/epw_pkg.sv
package epw_pkg;

  localparam int ADDR_W = 6;
  localparam int RAM_ADDR_W = 16;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_RAM_ADDR = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CMD = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 6'h10;

  localparam int CTRL_BUSY_BIT = 0;
  localparam int STATUS_MODE_BIT = 0;
  localparam int STATUS_PEND_BIT = 1;
  localparam int STATUS_OVR_BIT = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bit counter positions inside one frame
  localparam logic [3:0] FLAG_IDX = 4'h0;
  localparam logic [3:0] LAST_4W = 4'h7;
  localparam logic [3:0] LAST_3W = 4'h8;

  // aclk cycles after reset before the strap is caught (sync depth)
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef enum logic {EPW_MODE_4W, EPW_MODE_3W} epw_mode_t;

  typedef struct packed {
    logic stb;
    logic [7:0] value;
  } epw_cmd_t;

  typedef struct packed {
    logic en;
    logic [RAM_ADDR_W-1:0] addr;
    logic [7:0] value;
  } epw_ram_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic flag;
    logic [7:0] shift;
  } epw_frame_t;

  typedef struct packed {
    logic tog;
    logic dc;
    logic [7:0] value;
  } epw_handoff_t;

  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] catch_cnt;
    logic caught;
    epw_mode_t mode;
    logic tog_prev;
    logic busy;
    logic [RAM_ADDR_W-1:0] ram_addr;
    logic pending;
    logic overrun;
    logic [15:0] count;
    epw_cmd_t cmd;
    epw_ram_t ram;
  } epw_core_t;

endpackage : epw_pkg

// >>> hw/epw_serial_port.sv
// What this block does
// - strap pin picks 4-wire or 3-wire serial mode; no other host mode.
// - serial clock pin clocks the receiver; serial data pin is its input.
// - 4-wire: eight-bit shift on each rising clock, msb first.
// - 4-wire: data/command pin sampled on eighth clock; byte committed then.
// - port is write only; nothing is ever returned to the host.
// - 3-wire: nine bits per frame, flag first then byte msb first.
// - 3-wire: flag 1 sends byte to display RAM, 0 to command register.
// - 3-wire: data/command pin ignored; host ties it low.
// - bits taken only while chip select is low.
// - strap low means 4-wire, strap high means 3-wire.
// - active-low hardware reset input resets all logic except the two-flop synchronizer (reset by aresetn only), receiver included.
`timescale 1ns/1ps
module epw_serial_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [epw_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [epw_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_sclk,
  input wire logic serial_in,
  input wire logic chip_select_n,
  input wire logic dc_select,
  input wire logic iface_strap,
  input wire logic hw_reset_n,
  output logic busy_out,
  output epw_pkg::epw_cmd_t cmd_out,
  output epw_pkg::epw_ram_t ram_out
);

  localparam epw_pkg::epw_core_t CORE_RST = '0;

  logic frame_clr;
  logic rx_last;
  logic [7:0] rx_byte;
  logic rx_dc;
  logic tog_s;
  logic strap_s;
  logic hw_rst_s;
  logic rst_n_int;
  logic ev;
  logic [epw_pkg::ADDR_W-1:0] waddr;
  logic [epw_pkg::ADDR_W-1:0] raddr;
  epw_pkg::epw_handoff_t ho_reg;
  epw_pkg::epw_handoff_t ho_next;
  epw_pkg::epw_core_t core_reg;
  epw_pkg::epw_core_t core_next;

  // link domain: receiver plus a toggle hand-off register
  assign frame_clr = chip_select_n | ~hw_reset_n;

  epw_frame_rx u_rx (
    .link_sclk(link_sclk),
    .frame_clr(frame_clr),
    .mode(core_reg.mode),
    .serial_in(serial_in),
    .dc_select(dc_select),
    .last_bit(rx_last),
    .byte_next(rx_byte),
    .dc_next(rx_dc)
  );

  always_comb
  begin
    ho_next = ho_reg;
    if (rx_last)
    begin
      ho_next.tog = ~ho_reg.tog;
      ho_next.value = rx_byte;
      ho_next.dc = rx_dc;
    end
  end

  // hand-off survives chip select so a finished byte is never lost
  always_ff @(posedge link_sclk or negedge hw_reset_n)
  begin
    if (!hw_reset_n)
      ho_reg <= '0;
    else
      ho_reg <= ho_next;
  end

  // crossing into aclk: toggle, strap and reset pin each pass two flops
  epw_sync2 #(
    .WIDTH(3)
  ) u_sync (
    .clk(aclk),
    .rst_n(aresetn),
    .d({ho_reg.tog, iface_strap, hw_reset_n}),
    .q({tog_s, strap_s, hw_rst_s})
  );

  assign rst_n_int = aresetn & hw_rst_s;

  // hand-off value is stable for many aclk cycles after the toggle lands
  assign ev = core_reg.caught & (tog_s ^ core_reg.tog_prev);

  assign waddr = {core_reg.awaddr[epw_pkg::ADDR_W-1:2], 2'h0};
  assign raddr = {s_axi_araddr[epw_pkg::ADDR_W-1:2], 2'h0};

  always_comb
  begin
    core_next = core_reg;
    core_next.cmd.stb = 1'b0;
    core_next.ram.en = 1'b0;
    core_next.tog_prev = tog_s;

    // strap caught once after reset; the link reads it as a static level
    if (!core_reg.caught)
    begin
      if (core_reg.catch_cnt == epw_pkg::STRAP_WAIT)
      begin
        core_next.caught = 1'b1;
        core_next.mode = strap_s ? epw_pkg::EPW_MODE_3W : epw_pkg::EPW_MODE_4W;
      end
      else
        core_next.catch_cnt = core_reg.catch_cnt + 2'h1;
    end

    // route committed bytes
    if (ev)
    begin
      core_next.count = core_reg.count + 16'h0001;
      if (ho_reg.dc)
      begin
        core_next.ram.en = 1'b1;
        core_next.ram.addr = core_reg.ram_addr;
        core_next.ram.value = ho_reg.value;
        core_next.ram_addr = core_reg.ram_addr + 16'h0001;
      end
      else
      begin
        core_next.cmd.stb = 1'b1;
        core_next.cmd.value = ho_reg.value;
      end
    end

    // write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      core_next.aw_got = 1'b1;
      core_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      core_next.w_got = 1'b1;
      core_next.wdata = s_axi_wdata;
      core_next.wstrb = s_axi_wstrb;
    end
    if (core_reg.bvalid && s_axi_bready)
      core_next.bvalid = 1'b0;
    if (core_reg.aw_got && core_reg.w_got)
    begin
      core_next.aw_got = 1'b0;
      core_next.w_got = 1'b0;
      core_next.bvalid = 1'b1;
      core_next.bresp = epw_pkg::RESP_OKAY;
      unique case (waddr)
        epw_pkg::OFF_CTRL:
        begin
          if (core_reg.wstrb[0])
            core_next.busy = core_reg.wdata[epw_pkg::CTRL_BUSY_BIT];
        end
        epw_pkg::OFF_STATUS:
        begin
          if (core_reg.wstrb[0] && core_reg.wdata[epw_pkg::STATUS_OVR_BIT])
            core_next.overrun = 1'b0;
        end
        epw_pkg::OFF_RAM_ADDR:
        begin
          // bus write of the pointer wins over the auto increment
          if (core_reg.wstrb[0])
            core_next.ram_addr[7:0] = core_reg.wdata[7:0];
          if (core_reg.wstrb[1])
            core_next.ram_addr[15:8] = core_reg.wdata[15:8];
        end
        epw_pkg::OFF_CMD, epw_pkg::OFF_COUNT:
        begin
          core_next.bresp = epw_pkg::RESP_OKAY;
        end
        default:
        begin
          core_next.bresp = epw_pkg::RESP_SLVERR;
        end
      endcase
    end

    // reads; a command read consumes the pending flag
    if (core_reg.rvalid && s_axi_rready)
      core_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      core_next.rvalid = 1'b1;
      core_next.rresp = epw_pkg::RESP_OKAY;
      core_next.rdata = 32'h0000_0000;
      unique case (raddr)
        epw_pkg::OFF_CTRL:
          core_next.rdata[epw_pkg::CTRL_BUSY_BIT] = core_reg.busy;
        epw_pkg::OFF_STATUS:
        begin
          core_next.rdata[epw_pkg::STATUS_MODE_BIT] = core_reg.mode;
          core_next.rdata[epw_pkg::STATUS_PEND_BIT] = core_reg.pending;
          core_next.rdata[epw_pkg::STATUS_OVR_BIT] = core_reg.overrun;
        end
        epw_pkg::OFF_RAM_ADDR:
          core_next.rdata[15:0] = core_reg.ram_addr;
        epw_pkg::OFF_CMD:
        begin
          core_next.rdata[7:0] = core_reg.cmd.value;
          core_next.pending = 1'b0;
        end
        epw_pkg::OFF_COUNT:
          core_next.rdata[15:0] = core_reg.count;
        default:
          core_next.rresp = epw_pkg::RESP_SLVERR;
      endcase
    end

    // set wins over a clear in the same cycle
    if (ev && !ho_reg.dc)
    begin
      core_next.pending = 1'b1;
      if (core_reg.pending)
        core_next.overrun = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!rst_n_int)
      core_reg <= CORE_RST;
    else
      core_reg <= core_next;
  end

  // one write and one read outstanding at most
  assign s_axi_awready = !core_reg.aw_got && !core_reg.bvalid;
  assign s_axi_wready = !core_reg.w_got && !core_reg.bvalid;
  assign s_axi_arready = !core_reg.rvalid;
  assign s_axi_bvalid = core_reg.bvalid;
  assign s_axi_bresp = core_reg.bresp;
  assign s_axi_rvalid = core_reg.rvalid;
  assign s_axi_rdata = core_reg.rdata;
  assign s_axi_rresp = core_reg.rresp;
  assign busy_out = core_reg.busy;
  assign cmd_out = core_reg.cmd;
  assign ram_out = core_reg.ram;

  a_cmd_route: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (ev && !ho_reg.dc) |=> (cmd_out.stb && !ram_out.en && cmd_out.value == $past(ho_reg.value)))
    else $error("command byte not sent to command register");

  a_data_route: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (ev && ho_reg.dc) |=> (ram_out.en && !cmd_out.stb && ram_out.value == $past(ho_reg.value)))
    else $error("data byte not sent to display RAM");

  a_ram_addr_step: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (ev && ho_reg.dc && !(core_reg.aw_got && core_reg.w_got))
    |=> core_reg.ram_addr == $past(core_reg.ram_addr) + 16'h0001)
    else $error("RAM pointer did not advance after a data byte");

  a_mode_static: assert property (@(posedge aclk) disable iff (!rst_n_int)
    core_reg.caught |=> (core_reg.caught && $stable(core_reg.mode)))
    else $error("serial mode changed after it was caught");

  a_mode_strap: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (!core_reg.caught && core_reg.catch_cnt == epw_pkg::STRAP_WAIT)
    |=> core_reg.mode == ($past(strap_s) ? epw_pkg::EPW_MODE_3W : epw_pkg::EPW_MODE_4W))
    else $error("serial mode does not follow the strap level");

  a_pending_set: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (ev && !ho_reg.dc) |=> ##1 1'b1 ##0 $past(core_reg.pending) == 1'b1)
    else $error("command pending flag lost");

  a_busy_write: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (core_reg.aw_got && core_reg.w_got && waddr == epw_pkg::OFF_CTRL && core_reg.wstrb[0])
    |=> busy_out == $past(core_reg.wdata[epw_pkg::CTRL_BUSY_BIT]))
    else $error("busy output does not follow control write");

  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before it was taken");

  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read data dropped before it was taken");

  a_one_dest: assert property (@(posedge aclk) disable iff (!rst_n_int)
    !(cmd_out.stb && ram_out.en))
    else $error("byte sent to both display RAM and command register");

  a_event_pulse: assert property (@(posedge aclk) disable iff (!rst_n_int)
    ev |=> !ev)
    else $error("one committed byte routed twice");

  a_count_step: assert property (@(posedge aclk) disable iff (!rst_n_int)
    ev |=> core_reg.count == $past(core_reg.count) + 16'h0001)
    else $error("byte counter did not advance");

  a_overrun_set: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (ev && !ho_reg.dc && core_reg.pending) |=> core_reg.overrun)
    else $error("overrun not flagged for an unread command");

  a_pending_read: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (s_axi_arvalid && s_axi_arready && raddr == epw_pkg::OFF_CMD && !(ev && !ho_reg.dc))
    |=> !core_reg.pending)
    else $error("command read did not clear pending");

  a_bad_write: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (core_reg.aw_got && core_reg.w_got && waddr > epw_pkg::OFF_COUNT) |=> s_axi_bresp == epw_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

  a_good_write: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (core_reg.aw_got && core_reg.w_got && waddr <= epw_pkg::OFF_COUNT) |=> s_axi_bresp == epw_pkg::RESP_OKAY)
    else $error("mapped write refused");

  a_bad_read: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (s_axi_arvalid && s_axi_arready && raddr > epw_pkg::OFF_COUNT)
    |=> (s_axi_rresp == epw_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000))
    else $error("unmapped read not refused");

  a_pin_reset: assert property (@(posedge aclk)
    !rst_n_int |=> (!busy_out && !cmd_out.stb && !ram_out.en && !s_axi_bvalid && !s_axi_rvalid))
    else $error("outputs not cleared by reset");

  a_catch_count: assert property (@(posedge aclk) disable iff (!rst_n_int)
    !core_reg.caught |=> (core_reg.caught || core_reg.catch_cnt == $past(core_reg.catch_cnt) + 2'h1))
    else $error("strap catch delay not counting");

  a_ram_addr_out: assert property (@(posedge aclk) disable iff (!rst_n_int)
    (ev && ho_reg.dc) |=> ram_out.addr == $past(core_reg.ram_addr))
    else $error("data byte written at wrong RAM address");

  a_busy_hold: assert property (@(posedge aclk) disable iff (!rst_n_int)
    !(core_reg.aw_got && core_reg.w_got && waddr == epw_pkg::OFF_CTRL) |=> $stable(busy_out))
    else $error("busy output moved without a control write");

endmodule : epw_serial_port

// >>> hw/epw_sync2.sv
`timescale 1ns/1ps
module epw_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } epw_sync_t;

  epw_sync_t st_reg;
  epw_sync_t st_next;

  always_comb
  begin
    st_next.meta = d;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.stable;

endmodule : epw_sync2

// >>> testbench/epw_host_model.sv
`timescale 1ns/1ps
module epw_host_model (
  output logic link_sclk,
  output logic serial_in,
  output logic chip_select_n,
  output logic dc_select
);
  initial
  begin
    link_sclk = 1'b0;
    serial_in = 1'b0;
    chip_select_n = 1'b1;
    dc_select = 1'b0;
  end

  // a released data line shows the inverse, never a stale bit
  task automatic select(input logic on);
    #7;
    chip_select_n <= ~on;
    if (!on)
      serial_in <= ~serial_in;
    #20;
  endtask : select

  // clock runs only inside a frame; n below a full frame aborts it
  task automatic send(input logic tw, input logic dc, input logic [7:0] v, input int n);
    logic [8:0] fr;
    fr = tw ? {dc, v} : {v, 1'b0};
    for (int i = 0; i < n; i++)
    begin
      serial_in <= fr[8-i];
      dc_select <= tw ? 1'b0 : ((i == 7) ? dc : ~dc);
      #16 link_sclk <= 1'b1;
      #16 link_sclk <= 1'b0;
    end
    serial_in <= ~serial_in;
    #300;
  endtask : send
endmodule : epw_host_model

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  compares++; \
  if ((got) !== (ex)) \
  begin \
    n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); \
  end
module testbench;
  typedef struct packed {
    logic is_ram;
    logic [15:0] addr;
    logic [7:0] val;
  } epw_exp_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hw_reset_n, iface_strap;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [2:0] prot;
  logic [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, busy_out, link_sclk, serial_in, chip_select_n, dc_select;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  epw_pkg::epw_cmd_t cmd_out;
  epw_pkg::epw_ram_t ram_out;
  int n_mismatch = 0;
  int compares = 0;
  epw_exp_t lq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  epw_exp_t el;
  logic [33:0] er;
  logic [1:0] eb;
  logic [15:0] a;
  logic [7:0] d;

  epw_serial_port u_epw_serial_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_sclk(link_sclk), .serial_in(serial_in),
    .chip_select_n(chip_select_n), .dc_select(dc_select), .iface_strap(iface_strap),
    .hw_reset_n(hw_reset_n), .busy_out(busy_out), .cmd_out(cmd_out), .ram_out(ram_out));
  epw_host_model u_epw_host_model (.link_sclk(link_sclk), .serial_in(serial_in),
    .chip_select_n(chip_select_n), .dc_select(dc_select));

  always #20 aclk = ~aclk;

  task automatic wr(input logic [5:0] ad, input logic [31:0] dt, input logic [1:0] rs);
    bq.push_back(rs);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    prot <= 3'($urandom);
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
        break;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [5:0] ad, input logic [31:0] ex, input logic [1:0] rs);
    rq.push_back({rs, ex});
    araddr <= ad;
    arvalid <= 1'b1;
    prot <= 3'($urandom);
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
        break;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // the pointer model moves only on whole data bytes
  task automatic frm(input logic tw, input logic dc, input logic [7:0] v, input int n);
    if (n == (tw ? 9 : 8))
    begin
      lq.push_back({dc, a, v});
      a = a + {15'h0, dc};
    end
    u_epw_host_model.send(tw, dc, v, n);
  endtask : frm

  task automatic drain;
    while (lq.size() != 0)
      @(posedge aclk);
    repeat (8) @(posedge aclk);
  endtask : drain

  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  always @(posedge aclk)
  begin
    if (bvalid === 1'b1 && bready === 1'b1)
    begin
      eb = bq.pop_front();
      `CHK("bresp", eb, bresp)
    end
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      er = rq.pop_front();
      `CHK("rresp", er[33:32], rresp)
      `CHK("rdata", er[31:0], rdata)
    end
    if (cmd_out.stb === 1'b1 || ram_out.en === 1'b1)
    begin
      el = (lq.size() != 0) ? lq.pop_front() : 'x;
      `CHK("dest", el.is_ram, ram_out.en)
      `CHK("byte", el.val, (ram_out.en === 1'b1) ? ram_out.value : cmd_out.value)
      `CHK("ram addr", el.is_ram ? el.addr : 16'h0001, el.is_ram ? ram_out.addr : {15'h0, cmd_out.stb})
    end
  end

  initial
  begin
    #200000;
    n_mismatch++;
    summarize;
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, iface_strap} = 6'h0;
    {awaddr, araddr, wdata} = 44'h0;
    {prot, wstrb} = 7'h0f;
    hw_reset_n = 1'b1;
    void'($urandom(32'h100c));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    for (int i = 0; i < 5; i++)
      rd(6'(i * 4), 32'h0, epw_pkg::RESP_OKAY);
    rd(6'h14, 32'h0, epw_pkg::RESP_SLVERR);
    wr(6'h14, 32'hffffffff, epw_pkg::RESP_SLVERR);
    wr(epw_pkg::OFF_CMD, $urandom, epw_pkg::RESP_OKAY);
    rd(epw_pkg::OFF_CMD, 32'h0, epw_pkg::RESP_OKAY);
    wr(epw_pkg::OFF_CTRL, 32'h1, epw_pkg::RESP_OKAY);
    `CHK("busy_out", 1'b1, busy_out)
    rd(epw_pkg::OFF_CTRL, 32'h1, epw_pkg::RESP_OKAY);
    wr(epw_pkg::OFF_CTRL, 32'h0, epw_pkg::RESP_OKAY);
    `CHK("busy_out", 1'b0, busy_out)
    $display("test registers done");
    a = 16'($urandom);
    wr(epw_pkg::OFF_RAM_ADDR, {16'h0, a}, epw_pkg::RESP_OKAY);
    u_epw_host_model.select(1'b1);
    frm(1'b0, 1'b0, 8'($urandom), 8);
    repeat (3) frm(1'b0, 1'b1, 8'($urandom), 8);
    u_epw_host_model.select(1'b0);
    drain;
    rd(epw_pkg::OFF_STATUS, 32'h2, epw_pkg::RESP_OKAY);
    u_epw_host_model.select(1'b1);
    frm(1'b0, 1'b1, 8'($urandom), 5);
    u_epw_host_model.select(1'b0);
    u_epw_host_model.select(1'b1);
    d = 8'($urandom);
    frm(1'b0, 1'b0, d, 8);
    u_epw_host_model.select(1'b0);
    drain;
    rd(epw_pkg::OFF_STATUS, 32'h6, epw_pkg::RESP_OKAY);
    rd(epw_pkg::OFF_CMD, {24'h0, d}, epw_pkg::RESP_OKAY);
    rd(epw_pkg::OFF_STATUS, 32'h4, epw_pkg::RESP_OKAY);
    wr(epw_pkg::OFF_STATUS, 32'h4, epw_pkg::RESP_OKAY);
    rd(epw_pkg::OFF_STATUS, 32'h0, epw_pkg::RESP_OKAY);
    rd(epw_pkg::OFF_COUNT, 32'h5, epw_pkg::RESP_OKAY);
    rd(epw_pkg::OFF_RAM_ADDR, {16'h0, a}, epw_pkg::RESP_OKAY);
    $display("test four wire done");
    // strap is only caught after a reset, so the pin reset switches modes
    iface_strap <= 1'b1;
    hw_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    hw_reset_n <= 1'b1;
    repeat (8) @(posedge aclk);
    a = 16'h0;
    rd(epw_pkg::OFF_STATUS, 32'h1, epw_pkg::RESP_OKAY);
    rd(epw_pkg::OFF_RAM_ADDR, 32'h0, epw_pkg::RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      u_epw_host_model.select(1'b1);
      frm(1'b1, k[0], 8'($urandom), (k == 2) ? 4 : 9);
      u_epw_host_model.select(1'b0);
    end
    drain;
    rd(epw_pkg::OFF_COUNT, 32'h3, epw_pkg::RESP_OKAY);
    rd(epw_pkg::OFF_RAM_ADDR, {16'h0, a}, epw_pkg::RESP_OKAY);
    // busy bit sits in lane 0; a write without it must leave busy alone
    wstrb <= 4'he;
    wr(epw_pkg::OFF_CTRL, 32'h1, epw_pkg::RESP_OKAY);
    `CHK("busy_out", 1'b0, busy_out)
    wstrb <= 4'h1;
    wr(epw_pkg::OFF_RAM_ADDR, 32'h0000_ab5a, epw_pkg::RESP_OKAY);
    rd(epw_pkg::OFF_RAM_ADDR, {16'h0, a[15:8], 8'h5a}, epw_pkg::RESP_OKAY);
    $display("test three wire done");
    `CHK("left over", 0, lq.size())
    summarize;
  end
endmodule : testbench
